// ### hw/pdmc_top.sv
// Power-down mode control: module gates, clock divider, sleep and standby
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module pdmc_top import pdmc_pkg::*; (
  input wire logic core_clk_i, // System clock, 40 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic reset_pin_n_i, // External reset pin, active low
  input wire logic wdt_ovf_i, // Watchdog overflow reset request
  input wire logic hw_standby_pin_n_i, // Hardware standby pin, active low
  input wire pdmc_bus_s bus_i, // Register port request
  output logic [7:0] rdata_o, // Read data, cycle after the read
  input wire pdmc_cpu_s cpu_i, // CPU events
  input wire logic [PDMC_NUM_MOD-1:0] periph_acc_i, // Peripheral accesses
  input wire logic io_access_i, // Current access targets internal I/O
  output logic [PDMC_NUM_MOD-1:0] periph_stop_o, // Module stop per peripheral
  output logic [PDMC_NUM_MOD-1:0] periph_acc_en_o, // Access allowed
  output logic cpu_clk_en_o, // Bus-master clock enable pulse
  output logic cpu_halt_o, // CPU halted, registers held
  output logic [4:0] bus_states_o, // Access length in bus-master states
  output logic irq_exc_o, // Start interrupt exception processing
  output logic reset_state_o, // Device held in reset state
  output pdmc_mode_e mode_o // Current operating mode
);

  // Whole module state
  typedef struct packed {
    logic [7:0] peripheral_gate_bit_a;
    logic [7:0] peripheral_gate_bit_b;
    logic [7:0] peripheral_gate_bit_c;
    logic [7:0] peripheral_gate_bit_d;
    logic [2:0] clk_div;
    logic [7:0] hw_standby_pin_n_ctrl;
    logic [PDMC_NUM_MOD-1:0] stop;
    logic [4:0] div_cnt;
    pdmc_mode_e mode;
    logic irq_exc;
    logic rst_state;
    logic [7:0] rdata;
  } pdmc_state_s;

  pdmc_state_s st; // Registered state
  pdmc_state_s next_st; // Next state
  logic [PDMC_NUM_MOD-1:0] gate_vec; // Gate bits in peripheral order
  logic [4:0] div_len; // Divider ratio minus one
  logic div_tick; // Divided clock enable
  logic rst_req; // Any reset source

  // Collect gate bits
  always_comb begin
    gate_vec = {st.peripheral_gate_bit_a[PDMC_BIT_TIMER], st.peripheral_gate_bit_a[PDMC_BIT_ADC],
                st.peripheral_gate_bit_b[PDMC_BIT_SER0], st.peripheral_gate_bit_b[PDMC_BIT_SER1],
                st.peripheral_gate_bit_c[PDMC_BIT_CAN], st.peripheral_gate_bit_d[PDMC_BIT_PWM],
                st.peripheral_gate_bit_d[PDMC_BIT_LCD]}; // RULE18
  end

  // Divider ratio: 2,4,8,16,32 for codes 1..5
  always_comb begin
    if (st.clk_div == PDMC_DIV_NONE || st.mode == PDMC_M_HIGH) begin
      div_len = 5'h0;
    end else if (st.clk_div > PDMC_DIV_MAX) begin
      div_len = 5'h1F;
    end else begin
      div_len = 5'((6'h1 << st.clk_div) - 6'h1); // RULE8
    end
  end

  assign div_tick = (st.div_cnt == div_len);
  assign rst_req = !reset_pin_n_i || wdt_ovf_i;

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.irq_exc = 1'b0;
    next_st.rdata = 8'h00;
    next_st.rst_state = rst_req; // RULE17
    next_st.div_cnt = div_tick ? 5'h0 : 5'(st.div_cnt + 5'h1);
    // Register writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        PDMC_OFS_PERIPHERAL_GATE_BIT_A: begin
          next_st.peripheral_gate_bit_a = bus_i.wdata; // RULE1
        end
        PDMC_OFS_PERIPHERAL_GATE_BIT_B: begin
          next_st.peripheral_gate_bit_b = bus_i.wdata; // RULE2
        end
        PDMC_OFS_PERIPHERAL_GATE_BIT_C: begin
          next_st.peripheral_gate_bit_c = bus_i.wdata; // RULE3
        end
        PDMC_OFS_PERIPHERAL_GATE_BIT_D: begin
          next_st.peripheral_gate_bit_d = bus_i.wdata & PDMC_MASK_PERIPHERAL_GATE_BIT_D; // RULE4 RULE21
        end
        PDMC_OFS_CLK_CTRL: begin
          next_st.clk_div = bus_i.wdata[2:0];
        end
        PDMC_OFS_HW_STANDBY_PIN_N_CTRL: begin
          next_st.hw_standby_pin_n_ctrl = bus_i.wdata;
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    // Register reads
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        PDMC_OFS_PERIPHERAL_GATE_BIT_A: next_st.rdata = st.peripheral_gate_bit_a;
        PDMC_OFS_PERIPHERAL_GATE_BIT_B: next_st.rdata = st.peripheral_gate_bit_b;
        PDMC_OFS_PERIPHERAL_GATE_BIT_C: next_st.rdata = st.peripheral_gate_bit_c;
        PDMC_OFS_PERIPHERAL_GATE_BIT_D: next_st.rdata = st.peripheral_gate_bit_d; // RULE21
        PDMC_OFS_CLK_CTRL: next_st.rdata = {5'h00, st.clk_div};
        PDMC_OFS_HW_STANDBY_PIN_N_CTRL: next_st.rdata = st.hw_standby_pin_n_ctrl;
        PDMC_OFS_STATUS: next_st.rdata = {5'h00, st.mode};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // Gates follow bits at the end of the bus cycle
    if (cpu_i.bus_cycle_end) begin
      next_st.stop = gate_vec; // RULE19
    end
    // Mode sequencing
    unique case (st.mode)
      PDMC_M_HIGH: begin
        if (cpu_i.sleep_exec) begin
          next_st.mode = st.hw_standby_pin_n_ctrl[PDMC_BIT_STANDBY_SELECT_BIT] ? PDMC_M_SW_HW_STANDBY_PIN_N
                                                     : PDMC_M_SLEEP;
        end else if (cpu_i.bus_cycle_end && st.clk_div != PDMC_DIV_NONE) begin
          next_st.mode = PDMC_M_MEDIUM; // RULE7
        end
      end
      PDMC_M_MEDIUM: begin
        if (cpu_i.sleep_exec) begin
          next_st.mode = st.hw_standby_pin_n_ctrl[PDMC_BIT_STANDBY_SELECT_BIT] ? PDMC_M_SW_HW_STANDBY_PIN_N // RULE12
                                                     : PDMC_M_SLEEP; // RULE11
        end else if (cpu_i.bus_cycle_end && st.clk_div == PDMC_DIV_NONE) begin
          next_st.mode = PDMC_M_HIGH; // RULE10
        end
      end
      PDMC_M_SLEEP: begin
        if (cpu_i.irq_wake) begin
          next_st.irq_exc = 1'b1; // RULE16
          next_st.mode = (st.clk_div != PDMC_DIV_NONE) ? PDMC_M_MEDIUM
                                                       : PDMC_M_HIGH; // RULE11
        end
      end
      PDMC_M_SW_HW_STANDBY_PIN_N: begin
        if (cpu_i.ext_irq_wake) begin
          next_st.irq_exc = 1'b1;
          next_st.mode = (st.clk_div != PDMC_DIV_NONE) ? PDMC_M_MEDIUM
                                                       : PDMC_M_HIGH; // RULE12
        end
      end
      PDMC_M_HW_HW_STANDBY_PIN_N: begin
        // Left to high speed as soon as the standby pin is high again
        if (hw_standby_pin_n_i) begin
          next_st.mode = PDMC_M_HIGH;
        end
      end
      default: begin
        next_st.mode = PDMC_M_HIGH;
      end
    endcase
    // Reset sources cancel all registers and every mode but a hardware standby held by the pin
    if (rst_req) begin
      next_st = '0;
      next_st.rst_state = 1'b1; // RULE13 RULE17
      next_st.mode = PDMC_M_HIGH;
      next_st.peripheral_gate_bit_a = PDMC_RST_PERIPHERAL_GATE_BIT_A;
      next_st.peripheral_gate_bit_b = PDMC_RST_PERIPHERAL_GATE_BIT_B;
      next_st.peripheral_gate_bit_c = PDMC_RST_PERIPHERAL_GATE_BIT_C;
      next_st.peripheral_gate_bit_d = PDMC_RST_PERIPHERAL_GATE_BIT_D;
      next_st.stop = '1;
    end
    // Hardware standby overrides the mode and the reset state
    if (!hw_standby_pin_n_i) begin
      next_st.mode = PDMC_M_HW_HW_STANDBY_PIN_N; // RULE14
      next_st.rst_state = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st.peripheral_gate_bit_a <= PDMC_RST_PERIPHERAL_GATE_BIT_A; // RULE1
      st.peripheral_gate_bit_b <= PDMC_RST_PERIPHERAL_GATE_BIT_B; // RULE2
      st.peripheral_gate_bit_c <= PDMC_RST_PERIPHERAL_GATE_BIT_C; // RULE3
      st.peripheral_gate_bit_d <= PDMC_RST_PERIPHERAL_GATE_BIT_D; // RULE4
      st.clk_div <= PDMC_DIV_NONE;
      st.hw_standby_pin_n_ctrl <= 8'h00;
      st.stop <= '1;
      st.div_cnt <= 5'h00;
      st.mode <= PDMC_M_HIGH;
      st.irq_exc <= 1'b0;
      st.rst_state <= 1'b1;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign rdata_o = st.rdata;
  assign periph_stop_o = st.stop; // RULE18
  assign periph_acc_en_o = periph_acc_i & ~st.stop; // RULE20
  assign cpu_halt_o = (st.mode != PDMC_M_HIGH)
                      && (st.mode != PDMC_M_MEDIUM); // RULE15
  assign cpu_clk_en_o = div_tick && !cpu_halt_o && !st.rst_state; // RULE8
  assign bus_states_o = io_access_i ? PDMC_IO_STATES
                                    : PDMC_MEM_STATES; // RULE9
  assign irq_exc_o = st.irq_exc;
  assign reset_state_o = st.rst_state;
  assign mode_o = st.mode;

  // Assertions
  chk_gate_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (cpu_i.bus_cycle_end && !rst_req) |=> (st.stop == $past(gate_vec)))
    else $error("gate not applied at cycle end"); // RULE19
  chk_access_block: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (periph_acc_en_o & st.stop) == '0)
    else $error("access passed to stopped module"); // RULE20
  chk_sleep_entry: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.mode == PDMC_M_MEDIUM && cpu_i.sleep_exec && rst_req == 1'b0
     && hw_standby_pin_n_i && !st.hw_standby_pin_n_ctrl[PDMC_BIT_STANDBY_SELECT_BIT])
    |=> mode_o == PDMC_M_SLEEP)
    else $error("sleep not entered"); // RULE11
  chk_sw_hw_standby_pin_n: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.mode == PDMC_M_MEDIUM && cpu_i.sleep_exec && !rst_req
     && hw_standby_pin_n_i && st.hw_standby_pin_n_ctrl[PDMC_BIT_STANDBY_SELECT_BIT])
    |=> mode_o == PDMC_M_SW_HW_STANDBY_PIN_N)
    else $error("software standby not entered"); // RULE12
  chk_reset_cancel: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (rst_req && hw_standby_pin_n_i) |=> (mode_o == PDMC_M_HIGH && reset_state_o))
    else $error("reset did not cancel mode"); // RULE13
  chk_hw_standby: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !hw_standby_pin_n_i |=> mode_o == PDMC_M_HW_HW_STANDBY_PIN_N)
    else $error("hardware standby not entered"); // RULE14
  chk_sleep_halt: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (mode_o == PDMC_M_SLEEP) |-> (cpu_halt_o && !cpu_clk_en_o))
    else $error("cpu runs in sleep"); // RULE15
  chk_wake_irq: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.mode == PDMC_M_SLEEP && cpu_i.irq_wake && !rst_req
     && hw_standby_pin_n_i) |=> (irq_exc_o && !cpu_halt_o))
    else $error("interrupt did not wake"); // RULE16
  chk_medium_exit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.mode == PDMC_M_MEDIUM && cpu_i.bus_cycle_end && !cpu_i.sleep_exec
     && st.clk_div == PDMC_DIV_NONE && !rst_req && hw_standby_pin_n_i)
    |=> mode_o == PDMC_M_HIGH)
    else $error("medium speed not left"); // RULE10
  chk_d_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (st.peripheral_gate_bit_d & ~PDMC_MASK_PERIPHERAL_GATE_BIT_D) == 8'h00)
    else $error("unused gate bits set"); // RULE21
  chk_io_double: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    io_access_i |-> bus_states_o == 5'(2 * PDMC_MEM_STATES))
    else $error("io access not doubled"); // RULE9
endmodule : pdmc_top

// ### hw/pdmc_pkg.sv
// Package with register map, field positions and types of the power-down control
// Contract
// RULE1 - Register A: timer bit5, adc bit1, reset 1
// RULE2 - Register B: serial0 bit7, serial1 bit6, reset 1
// RULE3 - Register C: can bit3 reset 1
// RULE4 - Register D: pwm bit7, lcd bit6; low undefined
// RULE5 - Software writes 0 to register A top bits
// RULE6 - Software writes 1 to other unassigned bits
// RULE7 - Nonzero divider enters medium speed after cycle
// RULE8 - Medium speed divides bus-master clock 2..32
// RULE9 - Accesses count divided states; io doubles memory
// RULE10 - Zero divider returns high speed after cycle
// RULE11 - Sleep with standby bit 0 enters sleep
// RULE12 - Sleep with standby bit 1 enters software standby
// RULE13 - Reset pin or watchdog cancels medium speed
// RULE14 - Hardware standby pin low enters hardware standby
// RULE15 - Sleep halts cpu, peripherals keep running
// RULE16 - Enabled unmasked interrupt wakes; masked ones don't
// RULE17 - Reset pin during sleep gives reset state
// RULE18 - Gate bit 1 stops module, 0 releases
// RULE19 - Gate change takes effect at bus cycle end
// RULE20 - Stopped module register access is blocked
// RULE21 - Register D low bits ignore writes, read zero
package pdmc_pkg;
  localparam logic [2:0] PDMC_OFS_PERIPHERAL_GATE_BIT_A = 3'h0;
  localparam logic [2:0] PDMC_OFS_PERIPHERAL_GATE_BIT_B = 3'h1;
  localparam logic [2:0] PDMC_OFS_PERIPHERAL_GATE_BIT_C = 3'h2;
  localparam logic [2:0] PDMC_OFS_PERIPHERAL_GATE_BIT_D = 3'h3;
  localparam logic [2:0] PDMC_OFS_CLK_CTRL = 3'h4;
  localparam logic [2:0] PDMC_OFS_HW_STANDBY_PIN_N_CTRL = 3'h5;
  localparam logic [2:0] PDMC_OFS_STATUS = 3'h6;
  localparam logic [7:0] PDMC_RST_PERIPHERAL_GATE_BIT_A = 8'h3F;
  localparam logic [7:0] PDMC_RST_PERIPHERAL_GATE_BIT_B = 8'hFF;
  localparam logic [7:0] PDMC_RST_PERIPHERAL_GATE_BIT_C = 8'hFF;
  localparam logic [7:0] PDMC_RST_PERIPHERAL_GATE_BIT_D = 8'hC0;
  localparam logic [7:0] PDMC_MASK_PERIPHERAL_GATE_BIT_D = 8'hC0;
  localparam int PDMC_BIT_TIMER = 5;
  localparam int PDMC_BIT_ADC = 1;
  localparam int PDMC_BIT_SER0 = 7;
  localparam int PDMC_BIT_SER1 = 6;
  localparam int PDMC_BIT_CAN = 3;
  localparam int PDMC_BIT_PWM = 7;
  localparam int PDMC_BIT_LCD = 6;
  localparam int PDMC_BIT_STANDBY_SELECT_BIT = 7;
  localparam logic [2:0] PDMC_DIV_NONE = 3'h0;
  localparam logic [2:0] PDMC_DIV_MAX = 3'h5;
  localparam logic [4:0] PDMC_MEM_STATES = 5'h1;
  localparam logic [4:0] PDMC_IO_STATES = 5'h2;
  localparam int PDMC_NUM_MOD = 7;

  // Operating modes
  typedef enum logic [2:0] {
    PDMC_M_HIGH, PDMC_M_MEDIUM, PDMC_M_SLEEP, PDMC_M_SW_HW_STANDBY_PIN_N, PDMC_M_HW_HW_STANDBY_PIN_N
  } pdmc_mode_e;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdmc_bus_s;

  // CPU events
  typedef struct packed {
    logic sleep_exec;
    logic irq_wake;
    logic ext_irq_wake;
    logic bus_cycle_end;
  } pdmc_cpu_s;
endpackage : pdmc_pkg

// ### testbench/pdmc_cpu_model.sv
// CPU model: ends bus cycles on the bus-master clock and passes events
`timescale 1ns/10ps
module pdmc_cpu_model import pdmc_pkg::*; (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic clk_en_i, // Bus-master clock enable
  input wire logic halt_i, // CPU halted
  input wire logic [2:0] ev_i, // Sleep, interrupt, external interrupt
  output pdmc_cpu_s cpu_o // Events towards the block
);
  logic ph; // Bus cycle phase: a cycle lasts two bus-master states

  // Phase steps only on bus-master clocks, cleared to 0 while halted
  always_ff @(posedge clk_i) begin
    if (!rstn_i || halt_i) begin
      ph <= 1'b0;
    end else if (clk_en_i) begin
      ph <= ~ph;
    end
  end

  // A halted CPU executes nothing, so it starts no bus cycle
  assign cpu_o = {ev_i[2] & ~halt_i, ev_i[1], ev_i[0],
                  ph & clk_en_i & ~halt_i};
endmodule : pdmc_cpu_model

// ### testbench/tb_top.sv
// Self-checking bench for the power-down mode control
`timescale 1ns/10ps
module tb_top import pdmc_pkg::*;;
  logic core_clk_i = 0, rstn_i = 0, reset_pin_n_i = 1, wdt_ovf_i = 0;
  logic hw_standby_pin_n_i = 1, io_access_i = 0; // Pins and access kind
  pdmc_bus_s bus_i = '0; // Register port
  logic [7:0] rdata_o; // Read data
  logic [2:0] ev = '0; // Events sent through the CPU model
  pdmc_cpu_s cpu_i; // CPU events
  logic [6:0] periph_acc_i = '0, periph_stop_o, periph_acc_en_o;
  logic cpu_clk_en_o, cpu_halt_o, irq_exc_o, reset_state_o;
  logic [4:0] bus_states_o; // Access length
  pdmc_mode_e mode_o; // Operating mode
  int mismatches = 0, n_checks = 0, cyc = 0, n; // Counters
  logic [31:0] seed = 32'h000046DA; // Random state, 18138
  logic [7:0] ra, rb, rc, rd, pd, v; // Shadow register values
  logic seen; // Interrupt exception pulse observed

  pdmc_top pdmc_top_i (.*);
  pdmc_cpu_model pdmc_cpu_model_i (.clk_i(core_clk_i), .rstn_i(rstn_i),
    .clk_en_i(cpu_clk_en_o), .halt_i(cpu_halt_o), .ev_i(ev), .cpu_o(cpu_i));

  // Clock at 40 MHz
  always #12.5 core_clk_i = ~core_clk_i;

  // Hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  // Xorshift generator
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected stop vector from register images
  function automatic logic [6:0] stops(input logic [7:0] a, b, c, d);
    return {a[PDMC_BIT_TIMER], a[PDMC_BIT_ADC], b[PDMC_BIT_SER0],
            b[PDMC_BIT_SER1], c[PDMC_BIT_CAN], d[PDMC_BIT_PWM],
            d[PDMC_BIT_LCD]};
  endfunction : stops

  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle register write
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i) bus_i <= '0;
  endtask : wr

  // One-cycle read, data checked in the following cycle
  task rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk_i) bus_i <= '0;
    #1 chk(rdata_o, e);
  endtask : rdc

  // Event pulse, noting any interrupt exception pulse
  task pulse(input logic [2:0] e);
    seen = 0;
    @(posedge core_clk_i) ev <= e;
    @(posedge core_clk_i) ev <= '0;
    repeat (4) begin
      #1 seen |= irq_exc_o;
      @(posedge core_clk_i);
    end
  endtask : pulse

  // Bounded wait for a mode, then compare
  task wait_mode(input pdmc_mode_e m);
    for (int i = 0; i < 200 && mode_o !== m; i++) begin
      @(posedge core_clk_i) #1;
    end
    chk({5'h0, mode_o}, {5'h0, m});
  endtask : wait_mode

  // Verdict
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rdc(PDMC_OFS_PERIPHERAL_GATE_BIT_A, 8'h3F);
    rdc(PDMC_OFS_PERIPHERAL_GATE_BIT_B, 8'hFF);
    rdc(PDMC_OFS_PERIPHERAL_GATE_BIT_C, 8'hFF);
    rdc(PDMC_OFS_PERIPHERAL_GATE_BIT_D, 8'hC0);
    chk({1'b0, periph_stop_o}, 8'h7F);
    chk({7'h0, reset_state_o}, 8'h00);
    pd = 8'hC0;
    // Random gate patterns, fixed bits of A, B and C kept as software must; D written fully random
    repeat (8) begin
      ra = (rnd() & 8'h22) | 8'h1D;
      rb = (rnd() & 8'hC0) | 8'h3F;
      rc = (rnd() & 8'h08) | 8'hF7;
      rd = rnd();
      periph_acc_i <= rd[6:0];
      wr(PDMC_OFS_PERIPHERAL_GATE_BIT_A, ra);
      wr(PDMC_OFS_PERIPHERAL_GATE_BIT_B, rb);
      wr(PDMC_OFS_PERIPHERAL_GATE_BIT_C, rc);
      wr(PDMC_OFS_PERIPHERAL_GATE_BIT_D, rd);
      #1 chk({6'h0, periph_stop_o[1:0]}, {6'h0, pd[7:6]});
      repeat (3) @(posedge core_clk_i);
      #1 chk({1'b0, periph_stop_o}, {1'b0, stops(ra, rb, rc, rd)});
      chk({1'b0, periph_acc_en_o},
          {1'b0, rd[6:0] & ~stops(ra, rb, rc, rd)});
      rdc(PDMC_OFS_PERIPHERAL_GATE_BIT_A, ra);
      rdc(PDMC_OFS_PERIPHERAL_GATE_BIT_D, {rd[7:6], 6'h00});
      pd = rd;
    end
    // Divider codes 1 to 5
    for (int k = 1; k <= 5; k++) begin
      wr(PDMC_OFS_CLK_CTRL, 8'(k));
      wait_mode(PDMC_M_MEDIUM);
      n = 0;
      repeat (64) begin
        @(posedge core_clk_i) #1 n += cpu_clk_en_o;
      end
      chk(8'(n), 8'(64 >> k));
      v = rnd();
      @(posedge core_clk_i) io_access_i <= v[0];
      @(posedge core_clk_i) #1;
      chk({3'h0, bus_states_o}, v[0] ? 8'h02 : 8'h01);
    end
    // Sleep, a quiet spell, then an interrupt
    pulse(3'b100);
    wait_mode(PDMC_M_SLEEP);
    chk({7'h0, cpu_halt_o}, 8'h01);
    repeat (6) @(posedge core_clk_i);
    #1 chk({5'h0, mode_o}, {5'h0, PDMC_M_SLEEP});
    chk({1'b0, periph_stop_o}, {1'b0, stops(ra, rb, rc, rd)});
    rdc(PDMC_OFS_STATUS, {5'h0, PDMC_M_SLEEP});
    pulse(3'b010);
    chk({7'h0, seen}, 8'h01);
    wait_mode(PDMC_M_MEDIUM);
    // Software standby and external wake-up
    wr(PDMC_OFS_HW_STANDBY_PIN_N_CTRL, 8'h80);
    rdc(PDMC_OFS_HW_STANDBY_PIN_N_CTRL, 8'h80);
    pulse(3'b100);
    wait_mode(PDMC_M_SW_HW_STANDBY_PIN_N);
    pulse(3'b001);
    chk({7'h0, seen}, 8'h01);
    wait_mode(PDMC_M_MEDIUM);
    wr(PDMC_OFS_CLK_CTRL, 8'h00);
    wait_mode(PDMC_M_HIGH);
    // Sleep, then the hardware standby pin
    wr(PDMC_OFS_HW_STANDBY_PIN_N_CTRL, 8'h00);
    pulse(3'b100);
    wait_mode(PDMC_M_SLEEP);
    @(posedge core_clk_i) hw_standby_pin_n_i <= 1'b0;
    wait_mode(PDMC_M_HW_HW_STANDBY_PIN_N);
    @(posedge core_clk_i) hw_standby_pin_n_i <= 1'b1;
    wait_mode(PDMC_M_HIGH);
    // Reset pin during sleep, held for several cycles
    wr(PDMC_OFS_CLK_CTRL, 8'h02);
    wait_mode(PDMC_M_MEDIUM);
    pulse(3'b100);
    wait_mode(PDMC_M_SLEEP);
    @(posedge core_clk_i) reset_pin_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1 chk({7'h0, reset_state_o}, 8'h01);
    chk({5'h0, mode_o}, {5'h0, PDMC_M_HIGH});
    @(posedge core_clk_i) reset_pin_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 chk({7'h0, reset_state_o}, 8'h00);
    rdc(PDMC_OFS_CLK_CTRL, 8'h00);
    // Watchdog overflow in medium speed
    wr(PDMC_OFS_CLK_CTRL, 8'h01);
    wait_mode(PDMC_M_MEDIUM);
    @(posedge core_clk_i) wdt_ovf_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 chk({7'h0, reset_state_o}, 8'h01);
    chk({5'h0, mode_o}, {5'h0, PDMC_M_HIGH});
    @(posedge core_clk_i) wdt_ovf_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    tally_and_finish;
  end
endmodule : tb_top
